/* src/cache_bus_device.sv */
/*
 Processor end of the writeback cache bus: cycle issue, linefill intent,
 last-transfer marking, snoop hit reporting and writeback release.
 Assumes all bus inputs are asynchronous to clock and are synchronised.
*/
`timescale 1ns/1ps
module cache_bus_device #(
   parameter int unsigned BEATS = cache_bus_pkg::LINE_BEATS
) (
   input  wire logic   clock,
   input  wire logic   rstn,
   cache_bus_if.device bus,
   input  wire logic   reqValid,
   input  wire logic   reqWrite,
   input  wire logic   reqFill,
   output logic        reqReady,
   output logic        beatDone,
   output logic        cycleDone,
   output logic        wbDone,
   output logic        snoopProbe,
   input  wire logic   snoopLineValid,
   input  wire logic   snoopLineDirty,
   output logic        wbMode,
   output logic        modeReady
);
   // ************************************************************
   // Input synchronisers
   // ************************************************************
   logic [4:0] meta_q;
   logic [4:0] sync_q;
   logic [4:0] pins;

   assign pins = {bus.copyback_select, bus.snoop_strobe_n,
                  bus.burst_transfer_done_n, bus.transfer_done_n,
                  bus.fill_permit_n};

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta_q <= cache_bus_pkg::DEV_SYNC_RST;
         sync_q <= cache_bus_pkg::DEV_SYNC_RST;
      end else begin
         meta_q <= pins;
         sync_q <= meta_q;
      end
   end

   logic permitHigh;
   logic doneSeen;
   logic snoopSeen;
   logic strapLevel;
   assign permitHigh = sync_q[0];
   assign doneSeen   = !sync_q[1] || !sync_q[2];
   assign snoopSeen  = !sync_q[3];
   assign strapLevel = sync_q[4];

   // ************************************************************
   // Cycle and snoop state
   // ************************************************************
   typedef enum logic [1:0] {
      ST_IDLE, ST_ADDR, ST_DATA, ST_RELEASE
   } state_t;

   localparam int unsigned CW = $clog2(BEATS + 1);
   localparam logic [CW-1:0] BEATS_C = CW'(BEATS);
   localparam logic [CW-1:0] ONE_C   = CW'(1);

   state_t        state_q,   state_d;
   logic [1:0]    capCnt_q,  capCnt_d;
   logic          modeOk_q,  modeOk_d;
   logic          mode_q,    mode_d;
   logic          write_q,   write_d;
   logic          intent_q,  intent_d;
   logic          isWb_q,    isWb_d;
   logic [CW-1:0] beats_q,   beats_d;
   logic          match_q,   match_d;
   logic          dirty_q,   dirty_d;
   logic          beat_q,    beat_d;
   logic          cdone_q,   cdone_d;
   logic          wbdone_q,  wbdone_d;
   logic          finalLow;

   // Last beat, no intent, or a refused fill ends the cycle
   always_comb begin
      finalLow = (beats_q == ONE_C) || !intent_q ||
                 (!isWb_q && permitHigh);
   end

   always_comb begin
      state_d  = state_q;
      capCnt_d = capCnt_q;
      modeOk_d = modeOk_q;
      mode_d   = mode_q;
      write_d  = write_q;
      intent_d = intent_q;
      isWb_d   = isWb_q;
      beats_d  = beats_q;
      match_d  = match_q;
      dirty_d  = dirty_q;
      beat_d   = 1'b0;
      cdone_d  = 1'b0;
      wbdone_d = 1'b0;
      reqReady = 1'b0;

      // Strap is read only after the synchroniser has filled
      if (!modeOk_q) begin
         if (capCnt_q == cache_bus_pkg::MODE_CAPTURE) begin
            mode_d   = strapLevel;
            modeOk_d = 1'b1;
         end else begin
            capCnt_d = capCnt_q + 2'h1;
         end
      end

      case (state_q)
         ST_IDLE: begin
            if (modeOk_q && dirty_q) begin
               write_d  = 1'b1;
               intent_d = 1'b1;
               isWb_d   = 1'b1;
               beats_d  = BEATS_C;
               state_d  = ST_ADDR;
            end else if (modeOk_q) begin
               reqReady = 1'b1;
               if (reqValid) begin
                  write_d  = reqWrite;
                  intent_d = reqFill && !reqWrite;
                  isWb_d   = 1'b0;
                  beats_d  = BEATS_C;
                  state_d  = ST_ADDR;
               end
            end
         end
         ST_ADDR: begin
            state_d = ST_DATA;
         end
         ST_DATA: begin
            if (doneSeen) begin
               beat_d = 1'b1;
               if (finalLow) begin
                  cdone_d = 1'b1;
                  state_d = isWb_q ? ST_RELEASE : ST_IDLE;
               end else begin
                  beats_d = beats_q - ONE_C;
               end
            end
         end
         ST_RELEASE: begin
            // One clock after the last done, never past a new strobe
            dirty_d  = 1'b0;
            match_d  = 1'b0;
            wbdone_d = 1'b1;
            isWb_d   = 1'b0;
            state_d  = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase

      // Snoops only count in writeback mode; a new hit beats the release
      if (mode_q && snoopSeen && (!dirty_q || state_q == ST_RELEASE)) begin
         match_d = snoopLineValid;
         dirty_d = snoopLineValid && snoopLineDirty;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_q  <= ST_IDLE;
         capCnt_q <= 2'h0;
         modeOk_q <= 1'b0;
         mode_q   <= 1'b0;
         write_q  <= 1'b0;
         intent_q <= 1'b0;
         isWb_q   <= 1'b0;
         beats_q  <= '0;
         match_q  <= 1'b0;
         dirty_q  <= 1'b0;
         beat_q   <= 1'b0;
         cdone_q  <= 1'b0;
         wbdone_q <= 1'b0;
      end else begin
         state_q  <= state_d;
         capCnt_q <= capCnt_d;
         modeOk_q <= modeOk_d;
         mode_q   <= mode_d;
         write_q  <= write_d;
         intent_q <= intent_d;
         isWb_q   <= isWb_d;
         beats_q  <= beats_d;
         match_q  <= match_d;
         dirty_q  <= dirty_d;
         beat_q   <= beat_d;
         cdone_q  <= cdone_d;
         wbdone_q <= wbdone_d;
      end
   end

   // ************************************************************
   // Pin drive
   // ************************************************************
   logic inCycle;
   assign inCycle = (state_q == ST_ADDR) || (state_q == ST_DATA);

   // Every pin is driven from reset onward, in either cache mode
   assign bus.addr_strobe_n     = !(state_q == ST_ADDR);
   assign bus.cycle_write       = inCycle && write_q;
   assign bus.linefill_intent_n = !(inCycle && intent_q);
   assign bus.final_transfer_n  = !((state_q == ST_DATA) && finalLow);
   assign bus.snoop_match_n     = !match_q;
   assign bus.snoop_dirty_n     = !dirty_q;

   assign beatDone   = beat_q;
   assign cycleDone  = cdone_q;
   assign wbDone     = wbdone_q;
   assign snoopProbe = mode_q && snoopSeen;
   assign wbMode     = mode_q;
   assign modeReady  = modeOk_q;
endmodule

/* src/cache_bus_host.sv */
/*
 System controller end: cacheability permit, transfer done pulses,
 snoop strobe and the cache mode strap.
 Assumes device pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
module cache_bus_host #(
   parameter int unsigned BEATS = cache_bus_pkg::LINE_BEATS,
   parameter int unsigned GAP   = cache_bus_pkg::DONE_GAP
) (
   input  wire logic clock,
   input  wire logic rstn,
   cache_bus_if.host bus,
   input  wire logic wbStrap,
   input  wire logic permitFill,
   input  wire logic snoopReq,
   output logic      cycleStart,
   output logic      cycleWrite,
   output logic      cycleBurst,
   output logic      cycleEnd,
   output logic      snoopHit,
   output logic      snoopDirty
);
   // ************************************************************
   // Input synchronisers
   // ************************************************************
   logic [5:0] meta_q;
   logic [5:0] sync_q;
   logic [5:0] pins;

   assign pins = {bus.snoop_dirty_n, bus.snoop_match_n,
                  bus.final_transfer_n, bus.linefill_intent_n,
                  bus.cycle_write, bus.addr_strobe_n};

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta_q <= cache_bus_pkg::HOST_SYNC_RST;
         sync_q <= cache_bus_pkg::HOST_SYNC_RST;
      end else begin
         meta_q <= pins;
         sync_q <= meta_q;
      end
   end

   // ************************************************************
   // Cycle tracking and done generation
   // ************************************************************
   typedef enum logic [1:0] {H_IDLE, H_GAP, H_BEAT} hstate_t;

   localparam int unsigned CW = $clog2(BEATS + 1);
   localparam int unsigned GW = $clog2(GAP + 1);
   localparam logic [CW-1:0] BEATS_C = CW'(BEATS);
   localparam logic [CW-1:0] ONE_C   = CW'(1);
   localparam logic [GW-1:0] GAP_C   = GW'(GAP);
   localparam logic [GW-1:0] GONE_C  = GW'(1);

   hstate_t       state_q,  state_d;
   logic [CW-1:0] beats_q,  beats_d;
   logic [GW-1:0] gap_q,    gap_d;
   logic          burst_q,  burst_d;
   logic          write_q,  write_d;
   logic          permN_q,  permN_d;
   logic          rdyN_q,   rdyN_d;
   logic          brdyN_q,  brdyN_d;
   logic          snpN_q,   snpN_d;
   logic          strap_q,  strap_d;
   logic          start_q,  start_d;
   logic          end_q,    end_d;
   logic          burstNow;

   // A burst needs intent plus permit or a write; on a read, intent alone is not enough
   always_comb begin
      burstNow = !sync_q[2] && (sync_q[1] || !permN_q);
   end

   always_comb begin
      state_d = state_q;
      beats_d = beats_q;
      gap_d   = gap_q;
      burst_d = burst_q;
      write_d = write_q;
      permN_d = permN_q;
      rdyN_d  = 1'b1;
      brdyN_d = 1'b1;
      snpN_d  = !snoopReq;
      strap_d = wbStrap;
      start_d = 1'b0;
      end_d   = 1'b0;

      case (state_q)
         H_IDLE: begin
            // Permit held steady for the whole cycle
            permN_d = !permitFill;
            if (!sync_q[0]) begin
               permN_d = permN_q;
               burst_d = burstNow;
               write_d = sync_q[1];
               beats_d = burstNow ? BEATS_C : ONE_C;
               gap_d   = GAP_C;
               start_d = 1'b1;
               state_d = H_GAP;
            end
         end
         H_GAP: begin
            if (gap_q == GONE_C) begin
               state_d = H_BEAT;
            end else begin
               gap_d = gap_q - GONE_C;
            end
         end
         H_BEAT: begin
            rdyN_d  = burst_q;
            brdyN_d = !burst_q;
            if (beats_q == ONE_C) begin
               end_d   = 1'b1;
               state_d = H_IDLE;
            end else begin
               beats_d = beats_q - ONE_C;
               gap_d   = GAP_C;
               state_d = H_GAP;
            end
         end
         default: state_d = H_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_q <= H_IDLE;
         beats_q <= '0;
         gap_q   <= '0;
         burst_q <= 1'b0;
         write_q <= 1'b0;
         permN_q <= 1'b1;
         rdyN_q  <= 1'b1;
         brdyN_q <= 1'b1;
         snpN_q  <= 1'b1;
         strap_q <= 1'b0;
         start_q <= 1'b0;
         end_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         beats_q <= beats_d;
         gap_q   <= gap_d;
         burst_q <= burst_d;
         write_q <= write_d;
         permN_q <= permN_d;
         rdyN_q  <= rdyN_d;
         brdyN_q <= brdyN_d;
         snpN_q  <= snpN_d;
         strap_q <= strap_d;
         start_q <= start_d;
         end_q   <= end_d;
      end
   end

   assign bus.fill_permit_n         = permN_q;
   assign bus.transfer_done_n       = rdyN_q;
   assign bus.burst_transfer_done_n = brdyN_q;
   assign bus.snoop_strobe_n        = snpN_q;
   assign bus.copyback_select       = strap_q;

   assign cycleStart = start_q;
   assign cycleWrite = write_q;
   assign cycleBurst = burst_q;
   assign cycleEnd   = end_q;
   // Plain synchronised levels; no release clock is assumed
   assign snoopHit   = !sync_q[4];
   assign snoopDirty = !sync_q[5];
endmodule

/* src/cache_bus_if.sv */
/*
 Bus pins between the cache device end and the system controller end.
 Assumes the testbench instantiates it and binds both modports.
*/
`timescale 1ns/1ps
interface cache_bus_if;
   logic addr_strobe_n;
   logic cycle_write;
   logic linefill_intent_n;
   logic final_transfer_n;
   logic snoop_match_n;
   logic snoop_dirty_n;
   logic fill_permit_n;
   logic transfer_done_n;
   logic burst_transfer_done_n;
   logic snoop_strobe_n;
   logic copyback_select;

   modport device (
      output addr_strobe_n, cycle_write, linefill_intent_n,
             final_transfer_n, snoop_match_n, snoop_dirty_n,
      input  fill_permit_n, transfer_done_n, burst_transfer_done_n,
             snoop_strobe_n, copyback_select
   );
   modport host (
      input  addr_strobe_n, cycle_write, linefill_intent_n,
             final_transfer_n, snoop_match_n, snoop_dirty_n,
      output fill_permit_n, transfer_done_n, burst_transfer_done_n,
             snoop_strobe_n, copyback_select
   );
endinterface

/* src/cache_bus_pkg.sv */
/*
 Shared constants for the writeback cache bus signalling pair.
 Assumes both ends run on one clock and one active-low reset.
*/
package cache_bus_pkg;
   // ************************************************************
   // Timing and sizing
   // ************************************************************
   localparam int unsigned CLOCK_MHZ     = 250;
   localparam int unsigned LINE_BEATS    = 4;
   localparam int unsigned DONE_GAP      = 4;
   // Strap flop at the far end plus two sync stages must fill first
   localparam logic [1:0]  MODE_CAPTURE  = 2'h3;
   localparam logic [4:0]  DEV_SYNC_RST  = 5'h0f;
   localparam logic [5:0]  HOST_SYNC_RST = 6'h3d;
endpackage

/* verif/cache_bus_checker.sv */
/*
 Pin-level checks between the cache device end and the controller end.
 Assumes one clock, active-low async reset, instantiated by testbench.
*/
`timescale 1ns/1ps
module cache_bus_checker #(
   parameter int unsigned BEATS = 4
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic addr_strobe_n,
   input wire logic cycle_write,
   input wire logic linefill_intent_n,
   input wire logic final_transfer_n,
   input wire logic snoop_match_n,
   input wire logic snoop_dirty_n,
   input wire logic fill_permit_n,
   input wire logic transfer_done_n,
   input wire logic burst_transfer_done_n,
   input wire logic snoop_strobe_n,
   input wire logic copyback_select
);
   // ************************************************************
   // Writeback tracking
   // ************************************************************
   logic       wbOpen_q, wbOpen_d;
   logic [3:0] wbBeats_q, wbBeats_d, beats_q, beats_d;
   always_comb begin
      wbOpen_d = wbOpen_q;
      if (!addr_strobe_n && !snoop_dirty_n) wbOpen_d = 1'b1;
      else if (snoop_dirty_n) wbOpen_d = 1'b0;
      wbBeats_d = wbBeats_q + {3'h0, !burst_transfer_done_n};
      if (!wbOpen_q) wbBeats_d = 4'h0;
      beats_d = beats_q + {3'h0, !burst_transfer_done_n};
      if (!addr_strobe_n) beats_d = 4'h0;
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wbOpen_q  <= 1'b0;
         wbBeats_q <= 4'h0;
         beats_q   <= 4'h0;
      end else begin
         wbOpen_q  <= wbOpen_d;
         wbBeats_q <= wbBeats_d;
         beats_q   <= beats_d;
      end
   end
   // ************************************************************
   // Properties
   // ************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence fillStart;
      !addr_strobe_n && !cycle_write && !linefill_intent_n && fill_permit_n;
   endsequence
   sequence lastBurstBeat;
      !burst_transfer_done_n && int'(beats_q) == BEATS - 1;
   endsequence
   a_wt_snoop_high: assert property (
      !copyback_select |-> snoop_match_n && snoop_dirty_n)
      else $error("snoop pin low in writethrough mode");
   a_wt_write_intent: assert property (
      !addr_strobe_n && cycle_write && !copyback_select
      |-> linefill_intent_n)
      else $error("intent low on writethrough write");
   a_fill_single: assert property (
      fillStart |-> ##[1:40] !final_transfer_n)
      else $error("uncached fill never marked final");
   a_single_final: assert property (
      !transfer_done_n |-> !final_transfer_n)
      else $error("single done without final mark");
   a_burst_final: assert property (
      lastBurstBeat |-> !final_transfer_n)
      else $error("last burst beat without final mark");
   a_burst_permit: assert property (
      $fell(burst_transfer_done_n) && !cycle_write |-> !fill_permit_n)
      else $error("read burst without fill permit");
   a_hit_after_snoop: assert property (
      $fell(snoop_match_n) |-> !$past(snoop_strobe_n, 2) ||
      !$past(snoop_strobe_n, 3) || !$past(snoop_strobe_n, 4))
      else $error("snoop hit without snoop strobe");
   a_release_before_strobe: assert property (
      !addr_strobe_n && wbOpen_q |-> snoop_dirty_n)
      else $error("dirty still low at next strobe");
   a_release_after_done: assert property (
      $rose(snoop_dirty_n) |-> int'(wbBeats_q) == BEATS)
      else $error("dirty released before writeback finished");
endmodule

/* verif/testbench.sv */
/*
 Self-checking bench joining the device end and the controller end.
 Assumes the design files and the pin checker are compiled first.
*/
`timescale 1ns/1ps
module testbench;
   localparam int BEATS = cache_bus_pkg::LINE_BEATS;
   logic clock, rstn, reqValid, reqWrite, reqFill, reqReady, beatDone;
   logic cycleDone, wbDone, snoopProbe, snoopLineValid, snoopLineDirty;
   logic wbMode, modeReady, wbStrap, permitFill, snoopReq, cycleStart;
   logic cycleWrite, cycleBurst, cycleEnd, snoopHit, snoopDirty, modeWb;
   int   fail_count, samples_checked, expQ[$], e, i, ends, expN;
   cache_bus_if bus();
   cache_bus_device #(.BEATS(BEATS)) cache_bus_device_inst (.clock(clock),
      .rstn(rstn), .bus(bus), .reqValid(reqValid), .reqWrite(reqWrite),
      .reqFill(reqFill), .reqReady(reqReady), .beatDone(beatDone),
      .cycleDone(cycleDone), .wbDone(wbDone), .snoopProbe(snoopProbe),
      .snoopLineValid(snoopLineValid), .snoopLineDirty(snoopLineDirty),
      .wbMode(wbMode), .modeReady(modeReady));
   cache_bus_host #(.BEATS(BEATS), .GAP(cache_bus_pkg::DONE_GAP))
      cache_bus_host_inst (.clock(clock), .rstn(rstn), .bus(bus),
      .wbStrap(wbStrap), .permitFill(permitFill), .snoopReq(snoopReq),
      .cycleStart(cycleStart), .cycleWrite(cycleWrite),
      .cycleBurst(cycleBurst), .cycleEnd(cycleEnd), .snoopHit(snoopHit),
      .snoopDirty(snoopDirty));
   cache_bus_checker #(.BEATS(BEATS)) cache_bus_checker_inst (
      .clock(clock), .rstn(rstn), .addr_strobe_n(bus.addr_strobe_n),
      .cycle_write(bus.cycle_write), .linefill_intent_n(bus.linefill_intent_n),
      .final_transfer_n(bus.final_transfer_n),
      .snoop_match_n(bus.snoop_match_n), .snoop_dirty_n(bus.snoop_dirty_n),
      .fill_permit_n(bus.fill_permit_n), .transfer_done_n(bus.transfer_done_n),
      .burst_transfer_done_n(bus.burst_transfer_done_n),
      .snoop_strobe_n(bus.snoop_strobe_n),
      .copyback_select(bus.copyback_select));
   always #2 clock = ~clock;
   // ************************************************************
   // Compare and wait helpers
   // ************************************************************
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic cmp_bit(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic cmp_int(input string what, input int exp, input int got);
      samples_checked++;
      if (got != exp) begin
         fail_count++;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic chk_to(input string what, input int n, input int lim);
      if (n >= lim) begin
         fail_count++;
         $display("mismatch %s expected done seen timeout", what);
         end_of_test();
      end
   endtask
   // Model: each cycle the controller starts must match the queue head
   always @(posedge clock) begin
      if (rstn === 1'b1 && cycleStart === 1'b1) begin
         e = (expQ.size() > 0) ? expQ.pop_front() : 7;
         cmp_int("cycle queue", 1, int'(e < 4));
         cmp_bit("cycleWrite", e[1], cycleWrite);
         cmp_bit("cycleBurst", e[0], cycleBurst);
      end
      if (rstn === 1'b1 && cycleEnd === 1'b1) ends++;
   end
   // ************************************************************
   // Bus operations
   // ************************************************************
   task automatic do_reset(input logic wb);
      int n;
      rstn <= 1'b0;
      wbStrap <= wb;
      modeWb = wb;
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (modeReady !== 1'b1 && n < 50);
      chk_to("modeReady", n, 50);
      cmp_bit("wbMode", wb, wbMode);
   endtask
   task automatic do_req(input logic w, input logic f);
      int n, beats;
      logic b;
      @(posedge clock);
      b = !w && f && permitFill;
      expQ.push_back(int'({w, b}));
      expN++;
      reqValid <= 1'b1;
      reqWrite <= w;
      reqFill <= f;
      n = 0;
      #1;
      while (reqReady !== 1'b1 && n < 100) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk_to("reqReady", n, 100);
      @(posedge clock);
      reqValid <= 1'b0;
      beats = 0;
      n = 0;
      do begin
         @(posedge clock);
         #1;
         beats += int'(beatDone === 1'b1);
         n++;
      end while (cycleDone !== 1'b1 && n < 200);
      chk_to("cycleDone", n, 200);
      cmp_int("beats", b ? BEATS : 1, beats);
   endtask
   task automatic do_snoop(input logic v, input logic d);
      int n;
      int probes;
      logic hit;
      hit = modeWb && v;
      if (hit && d) begin
         expQ.push_back(3);
         expN++;
      end
      @(posedge clock);
      snoopLineValid <= v;
      snoopLineDirty <= d;
      snoopReq <= 1'b1;
      @(posedge clock);
      snoopReq <= 1'b0;
      probes = 0;
      repeat (10) begin
         @(posedge clock);
         #1;
         probes += int'(snoopProbe === 1'b1);
      end
      cmp_int("snoopProbe", int'(modeWb), probes);
      cmp_bit("snoopHit", hit, snoopHit);
      cmp_bit("snoopDirty", hit && d, snoopDirty);
      cmp_bit("dirty pin", !(hit && d), bus.snoop_dirty_n);
      // Writeback burst is under way here and carries intent low
      cmp_bit("intent pin", !(hit && d), bus.linefill_intent_n);
      if (hit && d) begin
         n = 0;
         do begin
            @(posedge clock);
            #1;
            n++;
         end while (wbDone !== 1'b1 && n < 300);
         chk_to("wbDone", n, 300);
         n = 0;
         do begin
            @(posedge clock);
            #1;
            n++;
         end while (snoopDirty !== 1'b0 && n < 10);
         cmp_bit("dirty released", 1'b0, snoopDirty);
         cmp_bit("match pin", 1'b1, bus.snoop_match_n);
      end
   endtask
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      clock = 1'b0;
      rstn = 1'b0;
      {reqValid, reqWrite, reqFill, snoopLineValid, snoopLineDirty} = 5'h00;
      {wbStrap, permitFill, snoopReq} = 3'h0;
      fail_count = 0;
      samples_checked = 0;
      void'($urandom(98027));
      do_reset(1'b0);
      permitFill <= 1'b1;
      do_req(1'b0, 1'b1);
      do_req(1'b1, 1'b0);
      do_req(1'b0, 1'b0);
      permitFill <= 1'b0;
      do_req(1'b0, 1'b1);
      do_snoop(1'b1, 1'b1);
      do_snoop(1'b1, 1'b0);
      $display("test writethrough finished");
      // Second reset in mid-run also flips the latched mode
      do_reset(1'b1);
      for (i = 0; i < 16; i++) begin
         @(posedge clock);
         permitFill <= 1'($urandom_range(0, 1));
         do_req(1'($urandom_range(0, 1)), 1'($urandom_range(0, 1)));
      end
      do_snoop(1'b1, 1'b0);
      do_snoop(1'b0, 1'b1);
      do_snoop(1'b1, 1'b1);
      do_req(1'b0, 1'b1);
      cmp_int("queue left", 0, expQ.size());
      cmp_int("cycle ends", expN, ends);
      $display("test writeback finished");
      end_of_test();
   end
endmodule
